// ==== hw/lan_link_led_indicator.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - The link/activity LED is dark whenever the link is down.
// - The link/activity LED is steadily lit while the link is up and idle.
// - Reported traffic makes the link/activity LED blink, overriding steady on.
// - In the 10/100 variant the yellow speed LED is dark at 10 Mbit/s.
// - In the 10/100 variant the yellow speed LED is lit at 100 Mbit/s.
// - In the gigabit variant both speed LED colours are dark at 10 Mbit/s.
// - In the gigabit variant only the green speed element is lit at 100 Mbit/s.
// - In the gigabit variant only the yellow speed element is lit at 1000 Mbit/s.
module lan_link_led_indicator #(
	parameter bit          GIGABIT  = 1'b1,
	parameter int unsigned HALF_CYC = lan_led_pkg::BLINK_HALF_CYC
) (
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	input  wire logic               linkUp,
	input  wire logic               txActivity,
	input  wire logic               rxActivity,
	input  wire lan_led_pkg::speed_t linkSpeed,
	output logic                    ledLinkAct,
	output logic                    ledSpeedYellow,
	output logic                    ledSpeedGreen
);
	import lan_led_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rstSync_q;
	logic       rstSync_n;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rstSync_q <= RESET_SYNC_INIT;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end

	assign rstSync_n = rstSync_q[1];

	// ----------------------------------------
	// Blink source
	// ----------------------------------------
	logic phaseTick;
	logic phaseLevel;

	blink_divider #(
		.HALF_CYC (HALF_CYC)
	) u_div (
		.clk_sys    (clk_sys),
		.rstSync_n  (rstSync_n),
		.phaseTick  (phaseTick),
		.phaseLevel (phaseLevel)
	);

	// ----------------------------------------
	// Activity stretch
	// ----------------------------------------
	// Hold counts three tick edges so a lone pulse spans a whole off/on period
	logic [1:0] hold_q;
	logic [1:0] hold_d;
	logic       anyActivity;
	logic       holdLive;

	assign anyActivity = txActivity | rxActivity;
	assign holdLive    = (hold_q != 2'h0);

	always_comb
	begin
		hold_d = hold_q;
		if (!linkUp)
		begin
			// Traffic with link down must not leave a stale blink
			hold_d = 2'h0;
		end
		else if (anyActivity)
		begin
			hold_d = HOLD_TICKS;
		end
		else if (phaseTick && holdLive)
		begin
			hold_d = hold_q - 2'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			hold_q <= 2'h0;
		end
		else
		begin
			hold_q <= hold_d;
		end
	end

	// ----------------------------------------
	// Link and activity LED
	// ----------------------------------------
	// Blink phase is shared, so a burst may start on either half
	logic ledLinkAct_q;
	logic ledLinkAct_d;

	always_comb
	begin
		if (!linkUp)
		begin
			ledLinkAct_d = 1'b0;
		end
		else if (holdLive)
		begin
			ledLinkAct_d = phaseLevel;
		end
		else
		begin
			ledLinkAct_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			ledLinkAct_q <= 1'b0;
		end
		else
		begin
			ledLinkAct_q <= ledLinkAct_d;
		end
	end

	// ----------------------------------------
	// Speed LED
	// ----------------------------------------
	// Speed ignores link state; the PHY reports a code even when down
	logic ledYel_q;
	logic ledYel_d;
	logic ledGrn_q;
	logic ledGrn_d;

	always_comb
	begin
		ledYel_d = 1'b0;
		ledGrn_d = 1'b0;
		if (GIGABIT)
		begin
			unique case (linkSpeed)
				SPEED_100:
				begin
					ledGrn_d = 1'b1;
				end
				SPEED_1000:
				begin
					ledYel_d = 1'b1;
				end
				default:
				begin
					// Reserved code falls back to the slow indication
					ledGrn_d = 1'b0;
				end
			endcase
		end
		else
		begin
			// Single colour part: green element never lit
			ledYel_d = (linkSpeed == SPEED_100);
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			ledYel_q <= 1'b0;
			ledGrn_q <= 1'b0;
		end
		else
		begin
			ledYel_q <= ledYel_d;
			ledGrn_q <= ledGrn_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Straight from flops so the jack sees no decode glitches

	assign ledLinkAct     = ledLinkAct_q;

	assign ledSpeedYellow = ledYel_q;

	assign ledSpeedGreen  = ledGrn_q;


endmodule : lan_link_led_indicator

// ==== hw/lan_led_pkg.sv ====
package lan_led_pkg;

	// ----------------------------------------
	// Speed codes reported by the PHY
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		SPEED_10   = 2'h0,
		SPEED_100  = 2'h1,
		SPEED_1000 = 2'h2,
		SPEED_RSVD = 2'h3
	} speed_t;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
	localparam int unsigned BLINK_HALF_MS    = 50;
	localparam int unsigned BLINK_HALF_CYC   = (CLK_FREQ_HZ / 1000) * BLINK_HALF_MS;
	localparam logic [1:0]  RESET_SYNC_INIT  = 2'h0;
	localparam logic [1:0]  HOLD_TICKS       = 2'h3;

endpackage : lan_led_pkg

// ==== hw/blink_divider.sv ====
`timescale 1ns/1ps

module blink_divider #(
	parameter int unsigned HALF_CYC = 5_000_000
) (
	input  wire logic clk_sys,
	input  wire logic rstSync_n,
	output logic      phaseTick,
	output logic      phaseLevel
);
	import lan_led_pkg::*;

	localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic          tick_q;
	logic          tick_d;
	logic          level_q;
	logic          level_d;

	// ----------------------------------------
	// Free-running divider
	// ----------------------------------------
	always_comb
	begin
		tick_d  = (count_q == LAST);
		count_d = tick_d ? '0 : count_q + CW'(1);
		level_d = tick_d ? ~level_q : level_q;
	end

	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			count_q <= '0;
			tick_q  <= 1'b0;
			level_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			tick_q  <= tick_d;
			level_q <= level_d;
		end
	end

	assign phaseTick  = tick_q;
	assign phaseLevel = level_q;

endmodule : blink_divider

// ==== verification/lan_led_sva.sv ====
`timescale 1ns/1ps
module lan_led_sva #(
	parameter bit          GIGABIT  = 1'b1,
	parameter int unsigned HALF_CYC = 4
) (
	input wire logic                clk_sys,
	input wire logic                reset_n,
	input wire logic                linkUp,
	input wire logic                txActivity,
	input wire logic                rxActivity,
	input wire lan_led_pkg::speed_t linkSpeed,
	input wire logic                ledLinkAct,
	input wire logic                ledSpeedYellow,
	input wire logic                ledSpeedGreen
);
	import lan_led_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire       act = txActivity | rxActivity;
	wire [1:0] spd = {ledSpeedYellow, ledSpeedGreen};
	// Link comes up quiet: hold must already be clear
	sequence upIdle_s;
		!linkUp ##1 linkUp && !act;
	endsequence
	darkDown_a: assert property ($past(reset_n, 3) && !$past(linkUp) |-> !ledLinkAct)
		else $error("link led lit");
	idleOn_a: assert property ($past(reset_n, 3) ##0 upIdle_s |=> ledLinkAct)
		else $error("idle led dark");
	downIgnore_a: assert property ($past(reset_n, 3) && act ##0 upIdle_s |=> ledLinkAct)
		else $error("stale blink");
	blink_a: assert property ($past(reset_n, 3) && linkUp && act |-> ##[1:10] !ledLinkAct)
		else $error("no blink");
	slowDark_a: assert property ($past(reset_n, 3) && $past(linkSpeed) inside {SPEED_10,
		SPEED_RSVD} |-> spd == 2'h0)
		else $error("speed led lit");
	greenSpeed_a: assert property ($past(reset_n, 3) |->
		ledSpeedGreen == (GIGABIT && $past(linkSpeed) == SPEED_100))
		else $error("green speed wrong");
	yellowSpeed_a: assert property ($past(reset_n, 3) |->
		ledSpeedYellow == ($past(linkSpeed) == (GIGABIT ? SPEED_1000 : SPEED_100)))
		else $error("yellow speed wrong");
	resetDark_a: assert property (!$past(reset_n, 2) |-> !ledLinkAct && spd == 2'h0)
		else $error("led lit after reset");
endmodule : lan_led_sva
bind lan_link_led_indicator lan_led_sva #(.GIGABIT(GIGABIT), .HALF_CYC(HALF_CYC)) i_lan_led_sva(
	.clk_sys, .reset_n, .linkUp, .txActivity, .rxActivity, .linkSpeed, .ledLinkAct,
	.ledSpeedYellow, .ledSpeedGreen);

// ==== verification/phy_model.sv ====
`timescale 1ns/1ps
module phy_model (
	input  wire logic [4:0]     knob,
	output logic                linkUp,
	output logic                txActivity,
	output logic                rxActivity,
	output lan_led_pkg::speed_t linkSpeed
);
	// Raw status: traffic may be reported with link down
	assign {linkUp, txActivity, rxActivity} = knob[4:2];
	assign linkSpeed = lan_led_pkg::speed_t'(knob[1:0]);
endmodule : phy_model

// ==== verification/lan_link_led_indicator_bench.sv ====
`timescale 1ns/1ps
module lan_link_led_indicator_bench;
	import lan_led_pkg::*;
	logic       clk_sys = 0, reset_n = 0, run = 0, led, yel, grn, linkUp, txActivity, rxActivity;
	logic [4:0] knob = 5'h0;
	logic [1:0] pSpd;
	logic       pLink, led10, yel10, grn10;
	speed_t     linkSpeed;
	int         num_errors = 0, cmp_count = 0, lows = 0;
	phy_model i_phy_model(.knob, .linkUp, .txActivity, .rxActivity, .linkSpeed);
	lan_link_led_indicator #(.HALF_CYC(4)) i_lan_link_led_indicator(.clk_sys, .reset_n,
		.linkUp, .txActivity, .rxActivity, .linkSpeed, .ledLinkAct(led),
		.ledSpeedYellow(yel), .ledSpeedGreen(grn));
	lan_link_led_indicator #(.GIGABIT(1'b0), .HALF_CYC(4)) i_lan_link_led_indicator_10(
		.clk_sys, .reset_n, .linkUp, .txActivity, .rxActivity, .linkSpeed,
		.ledLinkAct(led10), .ledSpeedYellow(yel10), .ledSpeedGreen(grn10));
	function automatic logic [1:0] expSpd(logic [1:0] s, bit gig);
		if (gig)
			return {s == SPEED_1000, s == SPEED_100};
		return {s == SPEED_100, 1'b0};
	endfunction : expSpd
	task automatic chk(string n, logic [1:0] e, logic [1:0] s);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("mismatch %s exp %b seen %b", n, e, s);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial forever #5 clk_sys = ~clk_sys;
	initial
	begin
		#20000 num_errors++;
		print_verdict();
	end
	always @(posedge clk_sys)
	begin
		pSpd  <= linkSpeed;
		pLink <= linkUp;
	end
	always @(negedge clk_sys)
		if (run)
		begin
			chk("speed", expSpd(pSpd, 1'b1), {yel, grn});
			chk("speed10", expSpd(pSpd, 1'b0), {yel10, grn10});
			if (!pLink)
				chk("down", 2'h0, {led10, led});
		end
	initial
	begin
		void'($urandom(32'hcf91));
		repeat (4) @(posedge clk_sys);
		reset_n <= 1;
		repeat (4) @(posedge clk_sys);
		run = 1;
		knob <= 5'h11;
		repeat (2) @(posedge clk_sys);
		knob <= 5'h19;
		@(posedge clk_sys) knob <= 5'h12;
		repeat (14) @(negedge clk_sys) lows += !led;
		chk("blink", 2'h1, 2'(lows >= 4));
		repeat (20) @(negedge clk_sys);
		chk("steady", 2'h1, {1'b0, led});
		repeat (400) @(posedge clk_sys) knob <= 5'($urandom);
		print_verdict();
	end
endmodule : lan_link_led_indicator_bench
